// ### hdl/emi_top.sv
// Purpose: bridge 32-bit internal requests to static memory and sdram
// Assumes: half-word and word requests are naturally aligned
// Notes:   static and sdram share one data bus; one request at a time
`timescale 1ns/100ps
// Functional notes
// - static path runs 8, 16 or 32 bits wide from x8 or x16 parts.
// - byte, half-word and word requests accepted at any region address.
// - 8-bit static word read takes four byte beats assembled into one word.
// - 32-bit static byte write enables only the addressed byte lane.
// - one select per byte lane; 16-bit adds one, 32-bit adds three.
// - static address has 20 lines, up to four more for 16 Mbytes.
// - static address bits above fitted size ignored, image repeats.
// - byte order is little-endian in every width.
// - read strobe asserts on falling edge, releases on rising edge.
// - read setup and active each half to 15.5 clocks, whole steps.
// - write strobe asserts on falling edge, releases on rising edge.
// - write setup and active each half to 15.5 clocks, whole steps.
// - write ends with hold of 0 to 15 clocks.
// - all static timings zero gives half-cycle strobes, no waits.
// - sdram path 8, 16 or 32 bits, one or two external banks.
// - 8-bit sdram word needs four reads; 32-bit uses data masks.
// - sdram address bits above fitted size ignored, image repeats.
// - 12-bit down-counter raises refresh request each interval.
// - power-down puts sdram into self-refresh.
// - sdram decoded only when top address nibble is 1100.
// - second bank select used only with two banks configured or during init.
// - row miss precharges the bank then activates the new row.
// - power-up always runs sdram init and loads the mode value.
// - precharge, activate, recovery, refresh periods are clock multiples.
module emi_top
	import emi_pkg::*;
#(
	parameter int INIT_WAIT = INIT_WAIT_CYC
)
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [31:0] req_addr,
	input  wire logic        req_write,
	input  wire logic [1:0]  req_size,
	input  wire logic [31:0] req_wdata,
	output logic             resp_valid,
	output logic             resp_error,
	output logic [31:0]      resp_rdata,
	input  wire logic [1:0]  st_width,
	input  wire logic        wide_device_select,
	input  wire logic [2:0]  st_extra_lines,
	input  wire logic [3:0]  rd_setup_field,
	input  wire logic [3:0]  rd_active_field,
	input  wire logic [3:0]  wr_setup_field,
	input  wire logic [3:0]  wr_active_field,
	input  wire logic [3:0]  wr_hold_field,
	input  wire logic [1:0]  dram_width,
	input  wire logic        dram_dual_bank,
	input  wire logic [1:0]  dram_col_sel,
	input  wire logic        dram_row13,
	input  wire logic [3:0]  precharge_period_field,
	input  wire logic [3:0]  activate_to_command_field,
	input  wire logic [3:0]  write_recovery_field,
	input  wire logic [3:0]  refresh_to_activate_field,
	input  wire logic [12:0] dram_mode_value,
	input  wire logic        refresh_enable,
	input  wire logic [11:0] refresh_interval,
	input  wire logic        power_down_req,
	output logic             dram_in_self_refresh,
	output logic             init_done,
	input  wire logic [31:0] mem_dq_in,
	output logic [31:0]      mem_dq_out,
	output logic             mem_dq_oe,
	output logic [23:0]      st_addr,
	output logic             st_base_select_n,
	output logic             byte_lane1_select_n,
	output logic             byte_lane2_select_n,
	output logic             byte_lane3_select_n,
	output logic             st_oe_n,
	output logic             st_we_n,
	output logic             dram_clock_out,
	output logic             dram_clock_gate,
	output logic [1:0]       dram_bank_select_n,
	output logic             dram_ras_n,
	output logic             dram_cas_n,
	output logic             dram_we_n,
	output logic [1:0]       dram_ba,
	output logic [12:0]      dram_addr,
	output logic [3:0]       dram_mask
);
	emi_state_e  st_q;
	emi_state_e  ret_q;
	logic [15:0] cnt_q;
	logic [31:0] cur_q;
	logic [31:0] wdata_q;
	logic [31:0] rdata_q;
	logic [3:0]  be_q;
	logic        wr_q;
	logic        is_dram_q;
	logic [1:0]  lg_q;
	logic [2:0]  beats_q;
	logic [3:0]  init_ref_q;
	logic        ref_pend_q;
	logic        ref_tick;
	logic [12:0] open_row_q [0:7];
	logic [7:0]  open_vld_q;
	logic        req_ready_q;
	logic        resp_valid_q;
	logic        resp_error_q;
	logic [31:0] resp_rdata_q;
	logic        self_q;
	logic        init_done_q;
	logic [31:0] dq_out_q;
	logic        dq_oe_q;
	logic [23:0] st_addr_q;
	logic [3:0]  sel_n_q;
	logic        rd_win_q;
	logic        wr_win_q;
	logic        rd_fall_q;
	logic        wr_fall_q;
	logic        ck_pos_q;
	logic        ck_neg_q;
	logic        cke_q;
	logic [1:0]  cs_n_q;
	logic [2:0]  cmd_q;
	logic [1:0]  ba_q;
	logic [12:0] da_q;
	logic [3:0]  mask_q;

	// ==========================================================
	// request decode
	logic        is_dr_req;
	logic [1:0]  lg_in;
	logic [1:0]  lg_raw;
	logic [3:0]  be_in;
	logic [2:0]  beats_in;

	assign is_dr_req = (req_addr[31:28] == DR_REGION);
	assign lg_raw    = is_dr_req ? dram_width : st_width;
	assign lg_in     = (lg_raw > W_32) ? W_32 : lg_raw;
	always_comb
	begin
		case (req_size)
			SZ_BYTE: be_in = 4'h1 << req_addr[1:0];
			SZ_HALF: be_in = req_addr[1] ? 4'hC : 4'h3;
			default: be_in = 4'hF;
		endcase
		// narrow paths split wide requests into beats
		beats_in = (req_size > lg_in) ? (3'h1 << (req_size - lg_in)) : 3'h1;
	end

	// ==========================================================
	// byte lanes, little-endian placement
	logic [1:0]  gmask;
	logic [1:0]  gb;
	logic [3:0]  lane_en;
	logic [31:0] lane_wdata;
	logic [31:0] cap_word;
	logic [3:0]  st_sel;

	assign gmask = (lg_q == W_8) ? 2'h3 : ((lg_q == W_16) ? 2'h2 : 2'h0);
	assign gb    = cur_q[1:0] & gmask;
	generate
		for (genvar g = 0; g < 4; g++)
		begin : g_lane
			logic [2:0] pos;
			logic [1:0] ext;
			assign pos = {1'b0, gb} + 3'(g);
			// lanes beyond the width stay idle
			assign lane_en[g] = (3'(g) < (3'h1 << lg_q)) && !pos[2] && be_q[pos[1:0]];
			assign lane_wdata[8*g+:8] = wdata_q[{pos[1:0], 3'b000}+:8];
			assign ext = 2'(g) - gb;
			assign cap_word[8*g+:8] = (((2'(g) & gmask) == gb) && be_q[g]) ?
				mem_dq_in[{ext, 3'b000}+:8] : rdata_q[8*g+:8];
		end
	endgenerate
	// x16 parts share one select per pair on reads
	assign st_sel = lane_en | ((wide_device_select && !wr_q && lg_q != W_8) ?
		{lane_en[2], lane_en[3], lane_en[0], lane_en[1]} : 4'h0);

	// ==========================================================
	// address split
	logic [2:0]  st_extra;
	logic [23:0] st_mask;
	logic [27:0] off;
	logic [27:0] off2;
	logic [27:0] off3;
	logic [3:0]  cb;
	logic [9:0]  col;
	logic [12:0] row;
	logic [1:0]  bank;
	logic        csel;
	logic [2:0]  idx;

	assign st_extra = (st_extra_lines > ST_MAX_EXTRA) ? ST_MAX_EXTRA : st_extra_lines;
	assign st_mask  = (24'h1 << (ST_BASE_LINES + st_extra)) - 24'h1;
	always_comb
	begin
		// mask, column, row, bank, select from the bottom up
		off  = cur_q[27:0] >> lg_q;
		cb   = 4'h8 + {2'h0, dram_col_sel};
		col  = 10'(off & ((28'h1 << cb) - 28'h1));
		off2 = off >> cb;
		row  = dram_row13 ? off2[12:0] : {1'b0, off2[11:0]};
		off3 = dram_row13 ? (off2 >> 13) : (off2 >> 12);
		bank = off3[1:0];
		csel = dram_dual_bank && off3[2]; // higher bits dropped
		idx  = {csel, bank};
	end

	// ==========================================================
	// sequencer
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			st_q <= ST_INIT_WAIT;
			ret_q <= ST_IDLE;
			cnt_q <= 16'(INIT_WAIT);
			cur_q <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			be_q <= '0;
			wr_q <= 1'b0;
			is_dram_q <= 1'b0;
			lg_q <= W_8;
			beats_q <= 3'h1;
			init_ref_q <= '0;
			ref_pend_q <= 1'b0;
			open_vld_q <= '0;
			req_ready_q <= 1'b0;
			resp_valid_q <= 1'b0;
			resp_error_q <= 1'b0;
			resp_rdata_q <= '0;
			self_q <= 1'b0;
			init_done_q <= 1'b0;
			dq_out_q <= '0;
			dq_oe_q <= 1'b0;
			st_addr_q <= '0;
			sel_n_q <= LANES_IDLE;
			rd_win_q <= 1'b0;
			wr_win_q <= 1'b0;
			cke_q <= 1'b0;
			cs_n_q <= CS_IDLE;
			cmd_q <= CMD_NOP;
			ba_q <= '0;
			da_q <= '0;
			mask_q <= MASK_NONE;
		end
		else
		begin
			cmd_q <= CMD_NOP;
			cs_n_q <= CS_IDLE;
			req_ready_q <= 1'b0;
			resp_valid_q <= 1'b0;
			case (st_q)
				ST_INIT_WAIT:
				begin
					if (cnt_q <= 16'h0001)
					begin
						cke_q <= 1'b1;
						st_q <= ST_INIT_PRE;
					end
					else
						cnt_q <= cnt_q - 16'h0001;
				end
				ST_INIT_PRE:
				begin
					cmd_q <= CMD_PRE; // both selects toggle
					cs_n_q <= CS_BOTH;
					da_q <= ADDR_ALL_BANKS;
					cnt_q <= {12'h0, precharge_period_field};
					ret_q <= ST_INIT_REF;
					st_q <= ST_D_WAIT;
				end
				ST_INIT_REF:
				begin
					cmd_q <= CMD_REF;
					cs_n_q <= CS_BOTH;
					init_ref_q <= init_ref_q + 4'h1;
					cnt_q <= {12'h0, refresh_to_activate_field};
					ret_q <= (init_ref_q == INIT_REFRESHES - 4'h1) ? ST_INIT_MODE : ST_INIT_REF;
					st_q <= ST_D_WAIT;
				end
				ST_INIT_MODE:
				begin
					cmd_q <= CMD_LMR;
					cs_n_q <= CS_BOTH;
					ba_q <= '0;
					da_q <= dram_mode_value;
					cnt_q <= MODE_LOAD_CYC;
					ret_q <= ST_IDLE;
					st_q <= ST_D_WAIT;
				end
				ST_IDLE:
				begin
					init_done_q <= 1'b1;
					if (req_valid && req_ready_q)
					begin
						cur_q <= req_addr;
						wdata_q <= req_wdata;
						wr_q <= req_write;
						be_q <= be_in;
						lg_q <= lg_in;
						beats_q <= beats_in;
						rdata_q <= '0;
						is_dram_q <= is_dr_req;
						resp_error_q <= 1'b0;
						if (is_dr_req || req_addr[31:24] == ST_REGION)
							st_q <= ST_BEAT;
						else
						begin
							resp_error_q <= 1'b1;
							st_q <= ST_DONE;
						end
					end
					else if (power_down_req)
						st_q <= ST_P_PRE;
					else if (ref_pend_q)
						st_q <= ST_R_PRE;
					else
						req_ready_q <= !ref_tick;
				end
				ST_BEAT:
				begin
					if (!is_dram_q)
					begin
						st_addr_q <= (cur_q[23:0] & st_mask) >> lg_q;
						sel_n_q <= ~st_sel;
						dq_out_q <= lane_wdata;
						dq_oe_q <= wr_q;
						// zero setup skips straight to the strobe
						if ((wr_q ? wr_setup_field : rd_setup_field) == 4'h0)
						begin
							rd_win_q <= !wr_q;
							wr_win_q <= wr_q;
							cnt_q <= {12'h0, wr_q ? wr_active_field : rd_active_field};
							st_q <= ST_S_ACTIVE;
						end
						else
						begin
							cnt_q <= {12'h0, wr_q ? wr_setup_field : rd_setup_field};
							st_q <= ST_S_SETUP;
						end
					end
					else if (!open_vld_q[idx])
					begin
						cmd_q <= CMD_ACT;
						cs_n_q <= csel ? 2'h1 : 2'h2;
						ba_q <= bank;
						da_q <= row;
						open_row_q[idx] <= row;
						open_vld_q[idx] <= 1'b1;
						cnt_q <= {12'h0, activate_to_command_field};
						ret_q <= ST_BEAT;
						st_q <= ST_D_WAIT;
					end
					else if (open_row_q[idx] != row)
					begin
						cmd_q <= CMD_PRE;
						cs_n_q <= csel ? 2'h1 : 2'h2;
						ba_q <= bank;
						da_q <= '0;
						open_vld_q[idx] <= 1'b0;
						cnt_q <= {12'h0, precharge_period_field};
						ret_q <= ST_BEAT;
						st_q <= ST_D_WAIT;
					end
					else
					begin
						cmd_q <= wr_q ? CMD_WR : CMD_RD;
						cs_n_q <= csel ? 2'h1 : 2'h2;
						ba_q <= bank;
						da_q <= {3'h0, col};
						mask_q <= ~lane_en;
						dq_out_q <= lane_wdata;
						dq_oe_q <= wr_q;
						// read latency taken from the loaded mode value
						cnt_q <= wr_q ? {12'h0, write_recovery_field} :
							{13'h0, dram_mode_value[6:4]} + 16'h0001;
						ret_q <= wr_q ? ST_FIN : ST_D_CAP;
						st_q <= ST_D_WAIT;
					end
				end
				ST_S_SETUP:
				begin
					if (cnt_q <= 16'h0001)
					begin
						rd_win_q <= !wr_q;
						wr_win_q <= wr_q;
						cnt_q <= {12'h0, wr_q ? wr_active_field : rd_active_field};
						st_q <= ST_S_ACTIVE;
					end
					else
						cnt_q <= cnt_q - 16'h0001;
				end
				ST_S_ACTIVE:
				begin
					if (cnt_q == 16'h0000)
					begin
						rd_win_q <= 1'b0; // released on a rising edge
						wr_win_q <= 1'b0;
						if (!wr_q)
							rdata_q <= cap_word;
						if (wr_q && wr_hold_field != 4'h0)
						begin
							cnt_q <= {12'h0, wr_hold_field};
							st_q <= ST_S_HOLD;
						end
						else
							st_q <= ST_FIN;
					end
					else
						cnt_q <= cnt_q - 16'h0001;
				end
				ST_S_HOLD:
				begin
					if (cnt_q <= 16'h0001)
						st_q <= ST_FIN;
					else
						cnt_q <= cnt_q - 16'h0001;
				end
				ST_D_WAIT:
				begin
					if (is_dram_q)
						dq_oe_q <= 1'b0;
					if (cnt_q <= 16'h0001)
						st_q <= ret_q;
					else
						cnt_q <= cnt_q - 16'h0001;
				end
				ST_D_CAP:
				begin
					rdata_q <= cap_word;
					st_q <= ST_FIN;
				end
				ST_FIN:
				begin
					sel_n_q <= LANES_IDLE;
					dq_oe_q <= 1'b0;
					if (beats_q <= 3'h1)
						st_q <= ST_DONE;
					else
					begin
						beats_q <= beats_q - 3'h1;
						cur_q <= cur_q + (32'h1 << lg_q);
						st_q <= ST_BEAT;
					end
				end
				ST_DONE:
				begin
					resp_valid_q <= 1'b1;
					resp_rdata_q <= rdata_q;
					st_q <= ST_IDLE;
				end
				ST_R_PRE:
				begin
					cmd_q <= CMD_PRE; // close every row first
					cs_n_q <= dram_dual_bank ? CS_BOTH : 2'h2;
					da_q <= ADDR_ALL_BANKS;
					cnt_q <= {12'h0, precharge_period_field};
					ret_q <= ST_R_REF;
					st_q <= ST_D_WAIT;
				end
				ST_R_REF:
				begin
					cmd_q <= CMD_REF;
					cs_n_q <= dram_dual_bank ? CS_BOTH : 2'h2;
					open_vld_q <= '0;
					ref_pend_q <= 1'b0;
					cnt_q <= {12'h0, refresh_to_activate_field};
					ret_q <= ST_IDLE;
					st_q <= ST_D_WAIT;
				end
				ST_P_PRE:
				begin
					cmd_q <= CMD_PRE;
					cs_n_q <= dram_dual_bank ? CS_BOTH : 2'h2;
					da_q <= ADDR_ALL_BANKS;
					cnt_q <= {12'h0, precharge_period_field};
					ret_q <= ST_P_ENTER;
					st_q <= ST_D_WAIT;
				end
				ST_P_ENTER:
				begin
					cmd_q <= CMD_REF; // refresh with clock gate low
					cs_n_q <= dram_dual_bank ? CS_BOTH : 2'h2;
					cke_q <= 1'b0;
					self_q <= 1'b1;
					open_vld_q <= '0;
					st_q <= ST_P_SELF;
				end
				ST_P_SELF:
				begin
					if (!power_down_req)
					begin
						cke_q <= 1'b1;
						self_q <= 1'b0;
						cnt_q <= {12'h0, refresh_to_activate_field};
						ret_q <= ST_IDLE;
						st_q <= ST_D_WAIT;
					end
				end
				default:
					st_q <= ST_IDLE;
			endcase
			// a tick in the clearing cycle is kept
			if (ref_tick)
				ref_pend_q <= 1'b1;
		end
	end

	// ==========================================================
	// half-cycle strobes and clock out
	// falling-edge copies let strobes start mid-cycle and end on a rising edge
	always_ff @(negedge clk_sys)
	begin
		if (reset)
		begin
			rd_fall_q <= 1'b0;
			wr_fall_q <= 1'b0;
			ck_neg_q <= 1'b0;
		end
		else
		begin
			rd_fall_q <= rd_win_q;
			wr_fall_q <= wr_win_q;
			ck_neg_q <= ck_pos_q;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			ck_pos_q <= 1'b0;
		else
			ck_pos_q <= !ck_pos_q;
	end

	emi_refresh_timer u_refresh (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.enable   (refresh_enable && init_done_q),
		.interval (refresh_interval),
		.tick     (ref_tick)
	);

	// ==========================================================
	// outputs
	assign req_ready            = req_ready_q;
	assign resp_valid           = resp_valid_q;
	assign resp_error           = resp_error_q;
	assign resp_rdata           = resp_rdata_q;
	assign dram_in_self_refresh = self_q;
	assign init_done            = init_done_q;
	assign mem_dq_out           = dq_out_q;
	assign mem_dq_oe            = dq_oe_q;
	assign st_addr              = st_addr_q;
	assign st_base_select_n     = sel_n_q[0];
	assign byte_lane1_select_n  = sel_n_q[1];
	assign byte_lane2_select_n  = sel_n_q[2];
	assign byte_lane3_select_n  = sel_n_q[3];
	assign st_oe_n              = !(rd_win_q && rd_fall_q);
	assign st_we_n              = !(wr_win_q && wr_fall_q);
	assign dram_clock_out       = ck_pos_q ^ ck_neg_q;
	assign dram_clock_gate      = cke_q;
	assign dram_bank_select_n   = cs_n_q;
	assign dram_ras_n           = cmd_q[2];
	assign dram_cas_n           = cmd_q[1];
	assign dram_we_n            = cmd_q[0];
	assign dram_ba              = ba_q;
	assign dram_addr            = da_q;
	assign dram_mask            = mask_q;
endmodule

// ### hdl/emi_pkg.sv
// Purpose: shared constants and state codes of the external memory interface
// Assumes: one system clock at 125 MHz
// Notes:   offsets, reset values and cycle counts live here only
package emi_pkg;
	// ==========================================================
	// address regions
	localparam logic [7:0]  ST_REGION      = 8'hD0;
	localparam logic [3:0]  DR_REGION      = 4'hC;
	localparam int          ST_BASE_LINES  = 20;
	localparam logic [2:0]  ST_MAX_EXTRA   = 3'h4;
	// ==========================================================
	// widths and sizes (width code equals log2 of bytes per beat)
	localparam logic [1:0]  W_8            = 2'h0;
	localparam logic [1:0]  W_16           = 2'h1;
	localparam logic [1:0]  W_32           = 2'h2;
	localparam logic [1:0]  SZ_BYTE        = 2'h0;
	localparam logic [1:0]  SZ_HALF        = 2'h1;
	localparam int          REF_CNT_W      = 12;
	// ==========================================================
	// timing
	localparam int          CLK_PERIOD_NS  = 8;
	localparam int          INIT_WAIT_NS   = 100000;
	localparam int          INIT_WAIT_CYC  = (INIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  INIT_REFRESHES = 4'h2;
	localparam logic [15:0] MODE_LOAD_CYC  = 16'h0002;
	// ==========================================================
	// sdram commands as {ras_n, cas_n, we_n}
	localparam logic [2:0]  CMD_NOP        = 3'h7;
	localparam logic [2:0]  CMD_ACT        = 3'h3;
	localparam logic [2:0]  CMD_RD         = 3'h5;
	localparam logic [2:0]  CMD_WR         = 3'h4;
	localparam logic [2:0]  CMD_PRE        = 3'h2;
	localparam logic [2:0]  CMD_REF        = 3'h1;
	localparam logic [2:0]  CMD_LMR        = 3'h0;
	localparam logic [12:0] ADDR_ALL_BANKS = 13'h0400;
	// ==========================================================
	// reset values and the both-banks select
	localparam logic [1:0]  CS_IDLE        = 2'h3;
	localparam logic [1:0]  CS_BOTH        = 2'h0;
	localparam logic [3:0]  LANES_IDLE     = 4'hF;
	localparam logic [3:0]  MASK_NONE      = 4'h0;

	typedef enum logic [4:0] {
		ST_INIT_WAIT = 5'h00,
		ST_INIT_PRE  = 5'h01,
		ST_INIT_REF  = 5'h02,
		ST_INIT_MODE = 5'h03,
		ST_IDLE      = 5'h04,
		ST_BEAT      = 5'h05,
		ST_S_SETUP   = 5'h06,
		ST_S_ACTIVE  = 5'h07,
		ST_S_HOLD    = 5'h08,
		ST_D_WAIT    = 5'h09,
		ST_D_CAP     = 5'h0A,
		ST_FIN       = 5'h0B,
		ST_DONE      = 5'h0C,
		ST_R_PRE     = 5'h0D,
		ST_R_REF     = 5'h0E,
		ST_P_PRE     = 5'h0F,
		ST_P_ENTER   = 5'h10,
		ST_P_SELF    = 5'h11
	} emi_state_e;
endpackage

// ### hdl/emi_refresh_timer.sv
// Purpose: auto-refresh interval down-counter
// Assumes: interval is stable while enabled
// Notes:   clears to zero whenever disabled, ticks at once when enabled again
`timescale 1ns/100ps
module emi_refresh_timer
	import emi_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 reset,
	input  wire logic                 enable,
	input  wire logic [REF_CNT_W-1:0] interval,
	output logic                      tick
);
	logic [REF_CNT_W-1:0] cnt_q;
	logic                 tick_q;

	// ==========================================================
	// counter
	always_ff @(posedge clk_sys)
	begin
		if (reset || !enable)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else if (cnt_q == '0)
		begin
			cnt_q  <= interval;
			tick_q <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q - 1'b1;
			tick_q <= 1'b0;
		end
	end

	assign tick = tick_q;
endmodule

// ### bench/emi_chk.sv
// Purpose: port checks
// Assumes: one clock domain, sync reset
// Notes:   zero timing fields give half-cycle strobes
`timescale 1ns/100ps
module emi_chk
	import emi_pkg::*;
#(
	parameter int INIT_WAIT = 20
)
(
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic [31:0] req_addr,
	input wire logic        resp_valid,
	input wire logic        resp_error,
	input wire logic [3:0]  rd_setup_field,
	input wire logic [3:0]  rd_active_field,
	input wire logic [3:0]  wr_setup_field,
	input wire logic [3:0]  wr_active_field,
	input wire logic        dram_dual_bank,
	input wire logic        dram_in_self_refresh,
	input wire logic        init_done,
	input wire logic        st_oe_n,
	input wire logic        st_we_n,
	input wire logic        dram_clock_gate,
	input wire logic [1:0]  dram_bank_select_n,
	input wire logic        dram_ras_n,
	input wire logic        dram_cas_n,
	input wire logic        dram_we_n
);
	// ==========================================================
	// helpers
	logic [15:0] age_q;
	logic        unmapped;
	assign unmapped = req_addr[31:28] != DR_REGION && req_addr[31:24] != ST_REGION;
	// saturates: no wrap into init window
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			age_q <= 16'h0000;
		else if (age_q != 16'hFFFF)
			age_q <= age_q + 16'h0001;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// ==========================================================
	// assertions
	chk_take_drops_ready: assert property (req_valid && req_ready |=> !req_ready)
		else $error("ready high after take");
	chk_resp_one_cycle: assert property (resp_valid |=> !resp_valid)
		else $error("response too long");
	chk_unmapped_error: assert property (req_valid && req_ready && unmapped |-> ##2 resp_valid && resp_error)
		else $error("unmapped not refused");
	chk_single_bank_cs: assert property (init_done && !dram_dual_bank |-> dram_bank_select_n[1])
		else $error("second select with one bank");
	chk_self_ref_cke: assert property (dram_in_self_refresh |-> !dram_clock_gate)
		else $error("clock gate high in self refresh");
	chk_init_cke_low: assert property (age_q < INIT_WAIT - 1 |-> !dram_clock_gate && !init_done)
		else $error("init wait cut short");
	chk_init_blocks_req: assert property (!init_done |-> !req_ready)
		else $error("ready before init");
	chk_zero_rd_strobe: assert property (rd_setup_field == 4'h0 && rd_active_field == 4'h0 && !st_oe_n |=> st_oe_n)
		else $error("read strobe too long");
	chk_zero_wr_strobe: assert property (wr_setup_field == 4'h0 && wr_active_field == 4'h0 && !st_we_n |=> st_we_n)
		else $error("write strobe too long");
	cover property (resp_valid && resp_error);
	cover property (dram_in_self_refresh);
	cover property (!dram_ras_n && !dram_cas_n && dram_we_n && dram_clock_gate);
endmodule

bind emi_top emi_chk #(.INIT_WAIT(INIT_WAIT)) emi_chk_i (.*);

// ### bench/emi_mem_model.sv
// Purpose: byte-wide static parts, one per lane
// Assumes: 256 bytes per lane
// Notes:   released lanes never hold the last value
`timescale 1ns/100ps
module emi_mem_model
(
	input  wire logic        clk_sys,
	input  wire logic [23:0] st_addr,
	input  wire logic        st_base_select_n,
	input  wire logic        byte_lane1_select_n,
	input  wire logic        byte_lane2_select_n,
	input  wire logic        byte_lane3_select_n,
	input  wire logic        st_oe_n,
	input  wire logic        st_we_n,
	input  wire logic [31:0] mem_dq_out,
	output logic      [31:0] mem_dq_in
);
	// ==========================================================
	// storage
	logic [7:0]  mem [4][256];
	logic [3:0]  sel;
	logic [31:0] last_q;
	assign sel = ~{byte_lane3_select_n, byte_lane2_select_n, byte_lane1_select_n, st_base_select_n};
	// one byte slice per select
	always @(posedge clk_sys)
	begin
		if (!st_we_n)
			for (int i = 0; i < 4; i++)
				if (sel[i])
					mem[i][st_addr[7:0]] <= mem_dq_out[8*i +: 8];
		last_q <= mem_dq_in;
	end
	// undriven lanes toggle so a stale byte cannot pass
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			mem_dq_in[8*i +: 8] = (!st_oe_n && sel[i]) ? mem[i][st_addr[7:0]] : ~last_q[8*i +: 8];
	end
endmodule

// ### bench/tb.sv
// Purpose: scenario bench
// Assumes: x8 static parts, no sdram data model
// Notes:   short init wait for speed
`timescale 1ns/100ps
module tb
	import emi_pkg::*;
;
	logic clk_sys, reset, req_valid, req_ready, req_write, resp_valid, resp_error;
	logic [1:0] req_size, st_width, dram_width, dram_col_sel, dram_bank_select_n, dram_ba;
	logic [31:0] req_addr, req_wdata, resp_rdata, mem_dq_in, mem_dq_out, rd;
	logic [3:0] rd_setup_field, rd_active_field, wr_setup_field, wr_active_field, wr_hold_field;
	logic [3:0] precharge_period_field, activate_to_command_field, write_recovery_field;
	logic [3:0] refresh_to_activate_field, dram_mask, wr_mask;
	logic [2:0] st_extra_lines;
	logic [11:0] refresh_interval;
	logic [12:0] dram_mode_value, dram_addr;
	logic [23:0] st_addr;
	logic wide_device_select, dram_dual_bank, dram_row13, refresh_enable, power_down_req, err;
	logic dram_in_self_refresh, init_done, mem_dq_oe, st_base_select_n, byte_lane1_select_n;
	logic byte_lane2_select_n, byte_lane3_select_n, st_oe_n, st_we_n, dram_clock_out;
	logic dram_clock_gate, dram_ras_n, dram_cas_n, dram_we_n;
	int fails, samples_checked, beats, pres, refs, n;
	emi_top #(.INIT_WAIT(20)) emi_top_i (.*);
	emi_mem_model emi_mem_model_i (.*);
	// ==========================================================
	// monitors
	always @(negedge st_base_select_n) beats++;
	always @(posedge clk_sys)
		if (!dram_bank_select_n[0])
			case ({dram_ras_n, dram_cas_n, dram_we_n})
				CMD_PRE: pres++;
				CMD_REF: refs++;
				CMD_WR:  wr_mask = dram_mask;
				default: ;
			endcase
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic hold_until(ref logic sig);
		for (int k = 1; sig !== 1'b1; k++)
		begin
			@(negedge clk_sys);
			if (k > 3000)
			begin
				fails++;
				stop_test();
			end
		end
	endtask
	task automatic xfer(input logic [31:0] a, logic w, logic [1:0] sz, logic [31:0] wd);
		@(negedge clk_sys);
		{req_addr, req_write, req_size, req_wdata} = {a, w, sz, wd};
		req_valid = 1'b1;
		hold_until(req_ready);
		@(negedge clk_sys);
		req_valid = 1'b0;
		hold_until(resp_valid);
		rd = resp_rdata;
		err = resp_error;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_wide_lanes();
		xfer(32'hD0000010, 1'b1, 2'h2, 32'h44332211);
		xfer(32'hD0000012, 1'b1, SZ_BYTE, 32'h00AA0000);
		xfer(32'hD0000010, 1'b0, 2'h2, 32'h0);
		chk(rd, 32'h44AA2211);
		xfer(32'hD0100012, 1'b0, SZ_HALF, 32'h0);
		chk(rd, 32'h44AA0000);
		chk(32'(err), 32'h0);
	endtask
	task automatic t_unmapped();
		xfer(32'h80000000, 1'b0, 2'h2, 32'h0);
		chk(32'(err), 32'h1);
	endtask
	task automatic t_row_miss();
		pres = 0;
		xfer(32'hC0000001, 1'b1, SZ_BYTE, 32'h0000BB00);
		chk(32'(wr_mask), 32'hD);
		xfer(32'hC0000401, 1'b1, SZ_BYTE, 32'h0000BB00);
		chk(32'(pres), 32'h1);
	endtask
	task automatic t_refresh();
		refresh_enable = 1'b1;
		refs = 0;
		for (n = 0; refs == 0 && n < 100; n++)
			@(negedge clk_sys);
		chk(32'(refs), 32'h1);
		refs = 0;
		repeat (170) @(negedge clk_sys);
		chk(32'(refs), 32'hA);
		refresh_enable = 1'b0;
	endtask
	task automatic t_power_down();
		power_down_req = 1'b1;
		hold_until(dram_in_self_refresh);
		chk(32'(dram_clock_gate), 32'h0);
		power_down_req = 1'b0;
		xfer(32'hD0000010, 1'b0, 2'h2, 32'h0);
		chk(rd, 32'h44AA2211);
	endtask
	task automatic t_narrow_read();
		{st_width, wr_setup_field, wr_active_field, wr_hold_field} = {W_8, 12'h123};
		xfer(32'hD0000020, 1'b1, 2'h2, 32'hDDCCBBAA);
		beats = 0;
		xfer(32'hD0000020, 1'b0, 2'h2, 32'h0);
		chk(rd, 32'hDDCCBBAA);
		chk(32'(beats), 32'h4);
	endtask
	initial
	begin
		{reset, req_valid, req_write, req_size, req_addr, req_wdata} = {1'b1, 68'h0};
		{st_width, dram_width, dram_col_sel, st_extra_lines} = {W_32, W_32, 2'h0, 3'h0};
		{rd_setup_field, rd_active_field, wr_setup_field, wr_active_field, wr_hold_field} = 20'h0;
		{precharge_period_field, activate_to_command_field} = 8'h11;
		{write_recovery_field, refresh_to_activate_field} = 8'h11;
		{dram_mode_value, refresh_interval} = {13'h0020, 12'h010};
		wide_device_select = 1'b0;
		{dram_dual_bank, dram_row13, refresh_enable, power_down_req} = 4'h0;
		repeat (5) @(negedge clk_sys);
		reset = 1'b0;
		t_wide_lanes();
		t_unmapped();
		t_row_miss();
		t_refresh();
		t_power_down();
		t_narrow_read();
		stop_test();
	end
endmodule
